/* logic/pmc_pkg.sv */
// Summary of operation
// - up/down shows thresholds; 5 s timeout
// - enter edits threshold when free access
// - confirmed quick edit shown a few seconds
// - back held 2 s enters menu
// - password entry shows only edited digit
// - matching password opens first menu item
// - password 0000 skips; wrong returns to measurement
// - up/down step through items of level
// - enter on sub-menu opens its first item
// - enter on parameter starts editing it
// - back leaves level or menu
// - one minute idle leaves menu, not editing
// - digit edit: up/down digit, enter moves
// - enter held 2 s shows confirmation query
// - confirm enter stores, escape discards, to menu
// - slide up alone increases, accelerating
// - down briefly slows momentarily, held keeps slow
// - slide down alone decreases, mirrored slowing
// - list parameters cycle through one option
// - list enter asks, second enter stores
// - escape before acceptance discards edit
// - edit mode input picks digit or slide
// - panel activity never pauses measurement
package pmc_pkg;
  // clock and tick timing
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int TICK_MS = 10;
  localparam int TMR_W = 13;
  // least times round up, longest times round down
  localparam int LONG_MS = 2000;
  localparam int DEB_MS = 20;
  localparam int QUICK_MS = 5000;
  localparam int IDLE_MS = 60000;
  localparam int ERR_MS = 2000;
  localparam int SHOW_MS = 3000;
  localparam int ALT_MS = 1000;
  localparam int SLIDE_MS = 200;
  localparam int SLOW_MS = 500;
  localparam int ACC1_MS = 1000;
  localparam int ACC2_MS = 3000;
  localparam logic [7:0] LONG_TICKS = 8'((LONG_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [1:0] DEB_TICKS = 2'((DEB_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [TMR_W-1:0] QUICK_TICKS = TMR_W'(QUICK_MS / TICK_MS);
  localparam logic [TMR_W-1:0] IDLE_TICKS = TMR_W'(IDLE_MS / TICK_MS);
  localparam logic [TMR_W-1:0] ERR_TICKS = TMR_W'(ERR_MS / TICK_MS);
  localparam logic [TMR_W-1:0] SHOW_TICKS = TMR_W'(SHOW_MS / TICK_MS);
  localparam logic [6:0] ALT_TICKS = 7'(ALT_MS / TICK_MS);
  localparam logic [4:0] SLIDE_TICKS = 5'(SLIDE_MS / TICK_MS);
  localparam logic [5:0] SLOW_TICKS = 6'((SLOW_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [8:0] ACC1_TICKS = 9'(ACC1_MS / TICK_MS);
  localparam logic [8:0] ACC2_TICKS = 9'(ACC2_MS / TICK_MS);
  // value range and password code meaning none
  localparam logic signed [16:0] VAL_MIN = -17'sd999;
  localparam logic signed [16:0] VAL_MAX = 17'sd9999;
  localparam logic [15:0] PASS_NONE = 16'h0000;
  localparam logic [1:0] LEVEL_TOP = 2'h0;
  localparam logic [1:0] LEVEL_MAX = 2'h3;
  localparam logic [1:0] DIGIT_LAST = 2'h3;
  // what the display shows
  typedef enum logic [3:0] {
    DISP_MEAS, DISP_THR_NAME, DISP_THR_VALUE, DISP_ITEM_NAME,
    DISP_VALUE, DISP_LIST, DISP_PASS, DISP_PASS_ERR, DISP_CONFIRM
  } pmc_disp_mode_t;
  // one debounced button
  typedef struct packed {
    logic press;
    logic press_p;
    logic short_p;
    logic long_p;
  } pmc_btn_t;
  // display request
  typedef struct packed {
    pmc_disp_mode_t mode;
    logic [1:0] level;
    logic [3:0] index;
    logic [1:0] digit;
    logic flash;
    logic signed [15:0] value;
    logic [3:0] option;
  } pmc_disp_t;
  // store request to nonvolatile memory
  typedef struct packed {
    logic quick;
    logic list;
    logic [3:0] option;
    logic signed [15:0] value;
  } pmc_commit_t;
endpackage

/* logic/pmc_tick.sv */
`timescale 1ns/1ps
// divider making the slow timer tick
module pmc_tick #(
  parameter int CYCLES = 400000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  output logic tick_o
);
  localparam int CW = $clog2(CYCLES + 1);
  // cycle counter, wraps at the tick period
  logic [CW-1:0] cnt_q;
  wire logic last_w = (cnt_q == CW'(CYCLES - 1));

  // tick is registered so it is a clean one-cycle enable
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_q <= last_w ? '0 : cnt_q + 1'b1;
      tick_o <= last_w;
    end
  end
endmodule

/* logic/pmc_button.sv */
`timescale 1ns/1ps
// one front panel button: sync, debounce, short and long press
module pmc_button (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic pin_i,
  output pmc_pkg::pmc_btn_t btn_o
);
  import pmc_pkg::*;
  // three stage synchroniser; first stage feeds only the second
  logic s1_q, s2_q, s3_q;
  // debounced level and its settle counter
  logic lvl_q;
  logic [1:0] deb_q;
  // hold time in ticks, saturating at the long threshold
  logic [7:0] hold_q;
  // the raw pin is seen as changed once stages two and three agree
  wire logic agree_w = (s2_q == s3_q);
  wire logic diff_w = agree_w && (s3_q != lvl_q);
  wire logic flip_w = diff_w && tick_i && (deb_q == DEB_TICKS - 2'h1);
  wire logic rise_w = flip_w && !lvl_q;
  wire logic fall_w = flip_w && lvl_q;
  wire logic long_w = lvl_q && tick_i && (hold_q == LONG_TICKS - 8'h1);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      deb_q <= '0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (flip_w)
        lvl_q <= !lvl_q;
      // a bounce back restarts the settle time
      if (!diff_w || flip_w)
        deb_q <= '0;
      else if (tick_i)
        deb_q <= deb_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      hold_q <= '0;
      btn_o <= '0;
    end
    else
    begin
      if (!lvl_q)
        hold_q <= '0;
      else if (tick_i && hold_q != LONG_TICKS)
        hold_q <= hold_q + 8'h1;
      btn_o.press <= lvl_q;
      btn_o.press_p <= rise_w;
      // release before the threshold is a short press
      btn_o.short_p <= fall_w && (hold_q != LONG_TICKS);
      btn_o.long_p <= long_w;
    end
  end
endmodule

/* logic/pmc_panel_ctrl.sv */
`timescale 1ns/1ps
// front panel menu navigation and parameter editing
module pmc_panel_ctrl #(
  parameter int TICK_CYCLES = pmc_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic btn_up_i,
  input wire logic btn_down_i,
  input wire logic btn_enter_i,
  input wire logic back_menu_button_i,
  input wire logic free_access_i,
  input wire logic edit_slide_i,
  input wire logic [15:0] password_i,
  input wire logic [3:0] thr_count_i,
  input wire logic signed [15:0] thr_value_i,
  input wire logic [3:0] item_count_i,
  input wire logic item_is_menu_i,
  input wire logic item_is_list_i,
  input wire logic [3:0] list_count_i,
  input wire logic signed [15:0] value_i,
  input wire logic [3:0] option_i,
  output pmc_pkg::pmc_disp_t disp_o,
  output logic commit_o,
  output pmc_pkg::pmc_commit_t commit_data_o
);
  import pmc_pkg::*;

  typedef enum logic [2:0] {
    ST_MEAS, ST_QUICK, ST_SHOWNEW, ST_PASS, ST_PASS_ERR,
    ST_MENU, ST_EDIT, ST_CONFIRM
  } pmc_state_t;

  logic tick;
  pmc_btn_t up_b, dn_b, en_b, bk_b;

  pmc_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );
  pmc_button u_up (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tick_i(tick),
    .pin_i(btn_up_i), .btn_o(up_b)
  );
  pmc_button u_dn (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tick_i(tick),
    .pin_i(btn_down_i), .btn_o(dn_b)
  );
  pmc_button u_en (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tick_i(tick),
    .pin_i(btn_enter_i), .btn_o(en_b)
  );
  pmc_button u_bk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tick_i(tick),
    .pin_i(back_menu_button_i), .btn_o(bk_b)
  );

  // state and navigation
  pmc_state_t state_q, state_d;
  logic quick_q, quick_d; // edit was opened from quick view
  logic list_q, list_d; // edit is of a list parameter
  logic [1:0] level_q, level_d;
  logic [3:0][3:0] idx_q, idx_d; // selected item per level
  logic [3:0] thr_q, thr_d;
  logic [TMR_W-1:0] tmr_q, tmr_d; // timeout in ticks
  // edit working copies
  logic signed [15:0] val_q, val_d;
  logic [3:0] opt_q, opt_d;
  logic [1:0] digit_q, digit_d;
  logic [15:0] pass_q, pass_d; // four entered digits
  // slide rate state
  logic dir_up_q, dir_up_d;
  logic [4:0] slide_q, slide_d;
  logic [8:0] acc_q, acc_d;
  logic [5:0] both_q, both_d;
  // name/value alternation and digit flash
  logic [6:0] alt_q;
  logic phase_q;
  pmc_disp_t disp_d;
  logic commit_d;
  pmc_commit_t cdata_d;

  // step one place in a list, wrapping at either end
  function automatic logic [3:0] wrap_step(
    input logic [3:0] cur, input logic [3:0] cnt, input logic up);
    logic [3:0] r;
    r = cur;
    if (up)
      r = (cur + 4'h1 >= cnt) ? 4'h0 : cur + 4'h1;
    else
      r = (cur == 4'h0) ? cnt - 4'h1 : cur - 4'h1;
    return r;
  endfunction

  // add with clamp to the displayable range
  function automatic logic signed [15:0] clamp_add(
    input logic signed [15:0] v, input logic signed [15:0] d);
    logic signed [16:0] s;
    s = 17'(v) + 17'(d);
    if (s > VAL_MAX)
      s = VAL_MAX;
    else if (s < VAL_MIN)
      s = VAL_MIN;
    return s[15:0];
  endfunction

  // weight of the flashing digit, leftmost first
  function automatic logic signed [15:0] digit_weight(
    input logic [1:0] pos);
    logic signed [15:0] w;
    w = 16'sd1;
    unique case (pos)
      2'h0: w = 16'sd1000;
      2'h1: w = 16'sd100;
      2'h2: w = 16'sd10;
      2'h3: w = 16'sd1;
    endcase
    return w;
  endfunction

  // button events used by the state machine
  wire logic ud_p = up_b.press_p || dn_b.press_p;
  wire logic any_p = ud_p || en_b.press_p || bk_b.press_p;
  wire logic tmr_out = (tmr_q == '0);
  // quick view and its edit show the threshold index
  wire logic show_thr = (state_q == ST_QUICK) || (state_q == ST_SHOWNEW)
    || (quick_q && (state_q == ST_EDIT || state_q == ST_CONFIRM));
  // a new view opens on its name, not mid-alternation
  wire logic view_new = (state_d != state_q) || (thr_d != thr_q);
  wire logic [3:0] cur_idx = idx_q[level_q];
  wire logic [3:0] thr_nxt = wrap_step(thr_q, thr_count_i, 1'b1);
  wire logic [3:0] idx_nxt = wrap_step(cur_idx, item_count_i, up_b.press_p);
  wire logic [3:0] opt_nxt = wrap_step(opt_q, list_count_i, up_b.press_p);
  wire logic pass_ok = (pass_q == password_i);
  wire logic [3:0] pdig = pass_q[4'(15 - 4 * digit_q) -: 4];
  wire logic [3:0] pdig_nxt = up_b.press_p ?
    ((pdig == 4'h9) ? 4'h0 : pdig + 4'h1) :
    ((pdig == 4'h0) ? 4'h9 : pdig - 4'h1);
  wire logic signed [15:0] dig_step = up_b.press_p ?
    digit_weight(digit_q) : -digit_weight(digit_q);
  // slide rate decode
  wire logic slide_on = (state_q == ST_EDIT) && !list_q && edit_slide_i;
  wire logic held_any = up_b.press || dn_b.press;
  wire logic both_w = up_b.press && dn_b.press;
  wire logic slow_keep = (both_q == SLOW_TICKS);
  wire logic lone_p = (up_b.press_p && !dn_b.press)
    || (dn_b.press_p && !up_b.press);
  wire logic slide_go = lone_p
    || (tick && held_any && slide_q == 5'h0);
  wire logic signed [15:0] mag = both_w ? 16'sd1 :
    (acc_q < ACC1_TICKS) ? 16'sd1 :
    (acc_q < ACC2_TICKS) ? 16'sd10 : 16'sd100;
  // a lone press sets the direction of its own first step
  wire logic dir_w = (up_b.press_p && !dn_b.press) ||
    (dir_up_q && !(dn_b.press_p && !up_b.press));

  // next state and edit data
  always_comb
  begin
    state_d = state_q;
    quick_d = quick_q;
    list_d = list_q;
    level_d = level_q;
    idx_d = idx_q;
    thr_d = thr_q;
    tmr_d = (tick && !tmr_out) ? tmr_q - 1'b1 : tmr_q;
    val_d = val_q;
    opt_d = opt_q;
    digit_d = digit_q;
    pass_d = pass_q;
    dir_up_d = dir_up_q;
    slide_d = slide_q;
    acc_d = acc_q;
    both_d = both_q;
    commit_d = 1'b0;
    cdata_d = '{quick: quick_q, list: list_q, option: opt_q, value: val_q};
    unique case (state_q)
      ST_MEAS:
      begin
        if (ud_p)
        begin
          state_d = ST_QUICK;
          thr_d = '0;
          tmr_d = QUICK_TICKS;
        end
        else if (bk_b.long_p)
        begin
          level_d = LEVEL_TOP;
          idx_d = '0;
          tmr_d = IDLE_TICKS;
          if (password_i == PASS_NONE)
            state_d = ST_MENU;
          else
          begin
            state_d = ST_PASS;
            pass_d = '0;
            digit_d = '0;
          end
        end
      end
      ST_QUICK, ST_SHOWNEW:
      begin
        if (ud_p)
        begin
          state_d = ST_QUICK;
          thr_d = (state_q == ST_QUICK) ? thr_nxt : thr_q;
          tmr_d = QUICK_TICKS;
        end
        else if (en_b.short_p && free_access_i && state_q == ST_QUICK)
        begin
          state_d = ST_EDIT;
          quick_d = 1'b1;
          list_d = 1'b0;
          val_d = thr_value_i;
          digit_d = '0;
        end
        else if (bk_b.short_p || tmr_out)
          state_d = ST_MEAS;
      end
      ST_PASS:
      begin
        if (any_p)
          tmr_d = IDLE_TICKS;
        if (ud_p)
          pass_d[4'(15 - 4 * digit_q) -: 4] = pdig_nxt;
        else if (en_b.short_p && digit_q != DIGIT_LAST)
          digit_d = digit_q + 2'h1;
        else if (en_b.short_p)
        begin
          state_d = pass_ok ? ST_MENU : ST_PASS_ERR;
          tmr_d = pass_ok ? IDLE_TICKS : ERR_TICKS;
        end
        else if (bk_b.short_p || tmr_out)
          state_d = ST_MEAS;
      end
      ST_PASS_ERR:
      begin
        if (tmr_out)
          state_d = ST_MEAS;
      end
      ST_MENU:
      begin
        if (any_p)
          tmr_d = IDLE_TICKS;
        if (ud_p)
          idx_d[level_q] = idx_nxt;
        else if (en_b.short_p && item_is_menu_i && level_q != LEVEL_MAX)
        begin
          level_d = level_q + 2'h1;
          idx_d[level_q + 2'h1] = '0;
        end
        else if (en_b.short_p && !item_is_menu_i)
        begin
          state_d = ST_EDIT;
          quick_d = 1'b0;
          list_d = item_is_list_i;
          val_d = value_i;
          opt_d = option_i;
          digit_d = '0;
        end
        else if (bk_b.short_p)
        begin
          if (level_q == LEVEL_TOP)
            state_d = ST_MEAS;
          else
            level_d = level_q - 2'h1;
        end
        else if (tmr_out)
          state_d = ST_MEAS;
      end
      ST_EDIT:
      begin
        tmr_d = IDLE_TICKS;
        if (list_q && ud_p)
          opt_d = opt_nxt;
        else if (!edit_slide_i && ud_p)
          val_d = clamp_add(val_q, dig_step);
        else if (slide_on && slide_go)
          val_d = clamp_add(val_q, dir_w ? mag : -mag);
        if (!list_q && !edit_slide_i && en_b.short_p)
          digit_d = digit_q + 2'h1;
        if ((list_q && en_b.short_p) || (!list_q && en_b.long_p))
          state_d = ST_CONFIRM;
        else if (bk_b.short_p)
          state_d = quick_q ? ST_MEAS : ST_MENU;
      end
      ST_CONFIRM:
      begin
        if (en_b.short_p)
        begin
          commit_d = 1'b1;
          state_d = quick_q ? ST_SHOWNEW : ST_MENU;
          tmr_d = quick_q ? SHOW_TICKS : IDLE_TICKS;
        end
        else if (bk_b.short_p)
        begin
          state_d = quick_q ? ST_MEAS : ST_MENU;
          tmr_d = IDLE_TICKS;
        end
      end
    endcase
    // direction is taken from the button pressed alone
    dir_up_d = dir_w;
    // repeat period restarts on every step
    if (!held_any || lone_p)
      slide_d = SLIDE_TICKS - 5'h1;
    else if (tick)
      slide_d = (slide_q == 5'h0) ? SLIDE_TICKS - 5'h1 : slide_q - 5'h1;
    if (!both_w)
      both_d = '0;
    else if (tick && !slow_keep)
      both_d = both_q + 6'h1;
    // acceleration grows while held, reset by a held counter button
    if (!held_any || slow_keep)
      acc_d = '0;
    else if (tick && acc_q != ACC2_TICKS)
      acc_d = acc_q + 9'h1;
  end

  // display request from present state
  always_comb
  begin
    disp_d = '0;
    disp_d.level = level_q;
    disp_d.index = show_thr ? thr_q : cur_idx;
    disp_d.digit = digit_q;
    disp_d.flash = phase_q;
    disp_d.value = val_q;
    disp_d.option = opt_q;
    unique case (state_q)
      ST_MEAS: disp_d.mode = DISP_MEAS;
      ST_QUICK:
      begin
        disp_d.mode = phase_q ? DISP_THR_VALUE : DISP_THR_NAME;
        disp_d.value = thr_value_i;
      end
      ST_SHOWNEW:
        disp_d.mode = phase_q ? DISP_THR_VALUE : DISP_THR_NAME;
      ST_PASS:
      begin
        disp_d.mode = DISP_PASS;
        disp_d.value = {12'h000, pdig};
      end
      ST_PASS_ERR: disp_d.mode = DISP_PASS_ERR;
      ST_MENU: disp_d.mode = DISP_ITEM_NAME;
      ST_EDIT: disp_d.mode = list_q ? DISP_LIST : DISP_VALUE;
      ST_CONFIRM: disp_d.mode = DISP_CONFIRM;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_MEAS;
      quick_q <= 1'b0;
      list_q <= 1'b0;
      level_q <= LEVEL_TOP;
      idx_q <= '0;
      thr_q <= '0;
      tmr_q <= '0;
      val_q <= '0;
      opt_q <= '0;
      digit_q <= '0;
      pass_q <= '0;
      dir_up_q <= 1'b1;
      slide_q <= '0;
      acc_q <= '0;
      both_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      quick_q <= quick_d;
      list_q <= list_d;
      level_q <= level_d;
      idx_q <= idx_d;
      thr_q <= thr_d;
      tmr_q <= tmr_d;
      val_q <= val_d;
      opt_q <= opt_d;
      digit_q <= digit_d;
      pass_q <= pass_d;
      dir_up_q <= dir_up_d;
      slide_q <= slide_d;
      acc_q <= acc_d;
      both_q <= both_d;
    end
  end

  // alternation phase and registered outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      alt_q <= '0;
      phase_q <= 1'b0;
      disp_o <= '0;
      commit_o <= 1'b0;
      commit_data_o <= '0;
    end
    else
    begin
      if (view_new)
      begin
        alt_q <= '0;
        phase_q <= 1'b0;
      end
      else if (tick)
      begin
        alt_q <= (alt_q == ALT_TICKS - 7'h1) ? '0 : alt_q + 7'h1;
        if (alt_q == ALT_TICKS - 7'h1)
          phase_q <= !phase_q;
      end
      disp_o <= disp_d;
      commit_o <= commit_d;
      if (commit_d)
        commit_data_o <= cdata_d;
    end
  end
endmodule

/* verification/pmc_panel_chk.sv */
`timescale 1ns/1ps
// watches the panel controller ports for broken sequences
module pmc_panel_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic btn_up_i,
  input wire logic btn_down_i,
  input wire logic btn_enter_i,
  input wire logic back_menu_button_i,
  input wire logic free_access_i,
  input wire logic edit_slide_i,
  input wire logic [15:0] password_i,
  input wire logic [3:0] thr_count_i,
  input wire logic signed [15:0] thr_value_i,
  input wire logic [3:0] item_count_i,
  input wire logic item_is_menu_i,
  input wire logic item_is_list_i,
  input wire logic [3:0] list_count_i,
  input wire logic signed [15:0] value_i,
  input wire logic [3:0] option_i,
  input wire pmc_pkg::pmc_disp_t disp_o,
  input wire logic commit_o,
  input wire pmc_pkg::pmc_commit_t commit_data_o
);
  import pmc_pkg::*;
  // one tick of slack for the tick phase at press start
  localparam int unsigned HOLD_MIN = 199 * TICK_CYCLES;
  // cycles the raw back pin has been high, saturating
  int unsigned back_cnt_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !back_menu_button_i)
      back_cnt_q <= 0;
    else if (back_cnt_q != '1)
      back_cnt_q <= back_cnt_q + 1;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // error indicator must stay up, not flash past
  sequence s_err_shown;
    (disp_o.mode == DISP_PASS_ERR) [*8];
  endsequence
  property p_rst;
    $fell(rst_i) |-> disp_o.mode == DISP_MEAS && !commit_o;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle at reset");
  property p_hold;
    $past(disp_o.mode) == DISP_MEAS &&
      disp_o.mode inside {DISP_ITEM_NAME, DISP_PASS} |->
      back_cnt_q >= HOLD_MIN;
  endproperty
  a_hold: assert property (p_hold) else $error("menu too early");
  property p_pulse;
    commit_o |=> !commit_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("store too long");
  property p_cause;
    $rose(commit_o) |-> $past(disp_o.mode) == DISP_CONFIRM;
  endproperty
  a_cause: assert property (p_cause) else $error("store unasked");
  property p_edit;
    $past(disp_o.mode) == DISP_ITEM_NAME && disp_o.mode == DISP_VALUE |->
      disp_o.value == value_i;
  endproperty
  a_edit: assert property (p_edit) else $error("edit value");
  property p_digit;
    disp_o.mode == DISP_PASS |-> disp_o.value inside {[16'sd0:16'sd9]};
  endproperty
  a_digit: assert property (p_digit) else $error("code digit");
  property p_err;
    $rose(disp_o.mode == DISP_PASS_ERR) |-> s_err_shown;
  endproperty
  a_err: assert property (p_err) else $error("error too short");
  property p_sub;
    $past(disp_o.mode) == DISP_ITEM_NAME && disp_o.mode == DISP_ITEM_NAME &&
      disp_o.level > $past(disp_o.level) |->
      disp_o.level == $past(disp_o.level) + 2'h1 && disp_o.index == 4'h0;
  endproperty
  a_sub: assert property (p_sub) else $error("sub-menu entry");
endmodule

bind pmc_panel_ctrl pmc_panel_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .clk_sys_i, .rst_i, .btn_up_i, .btn_down_i, .btn_enter_i,
  .back_menu_button_i, .free_access_i, .edit_slide_i, .password_i,
  .thr_count_i, .thr_value_i, .item_count_i, .item_is_menu_i,
  .item_is_list_i, .list_count_i, .value_i, .option_i, .disp_o,
  .commit_o, .commit_data_o);

/* verification/pmc_operator.sv */
`timescale 1ns/1ps
// front panel operator: presses one button at a time
module pmc_operator #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_sys_i,
  output logic [3:0] pin_o
);
  // all buttons released, pins idle low
  initial pin_o = 4'h0;
  // contacts bounce first, so the debounce has real work to do
  task automatic press(input int b, input int n);
    @(posedge clk_sys_i) pin_o[b] <= 1'b1;
    @(posedge clk_sys_i) pin_o[b] <= 1'b0;
    @(posedge clk_sys_i) pin_o[b] <= 1'b1;
    repeat (n * TICK_CYCLES) @(posedge clk_sys_i);
    pin_o[b] <= 1'b0;
    // room for release debounce and the display update
    repeat (6 * TICK_CYCLES) @(posedge clk_sys_i);
  endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import pmc_pkg::*;
  // short tick keeps long presses and timeouts cheap
  localparam int TC = 10;
  localparam int UP = 0;
  localparam int DN = 1;
  localparam int EN = 2;
  localparam int BK = 3;
  localparam int LONG = 210;
  logic clk_sys_i;
  logic rst_i = 1'b1;
  logic [3:0] pin;
  logic edit_slide_i = 1'b0;
  logic free_access_i = 1'b0;
  logic [15:0] password_i = 16'h0000;
  logic signed [15:0] thr_value_i = 16'sh0000;
  logic item_is_menu_i = 1'b0;
  logic item_is_list_i = 1'b0;
  logic signed [15:0] value_i = 16'sh0000;
  pmc_disp_t disp_o;
  logic commit_o;
  pmc_commit_t commit_data_o;
  // random source and expected stores, oldest first
  logic [31:0] lfsr_q = 32'hf4ce;
  logic signed [15:0] v;
  pmc_commit_t exp_q[$];
  pmc_commit_t e;
  int n_mismatch = 0;
  int comparisons = 0;
  pmc_operator #(.TICK_CYCLES(TC)) op (.clk_sys_i, .pin_o(pin));
  pmc_panel_ctrl #(.TICK_CYCLES(TC)) i_pmc_panel_ctrl (
    .clk_sys_i, .rst_i, .btn_up_i(pin[0]), .btn_down_i(pin[1]),
    .btn_enter_i(pin[2]), .back_menu_button_i(pin[3]),
    .free_access_i, .edit_slide_i, .password_i, .thr_count_i(4'h3),
    .thr_value_i, .item_count_i(4'h4), .item_is_menu_i, .item_is_list_i,
    .list_count_i(4'h3), .value_i, .option_i(4'h1), .disp_o, .commit_o,
    .commit_data_o);
  // 40 MHz system clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string w, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask
  // display settles between edges
  task automatic mode_is(input string w, input pmc_disp_mode_t m);
    @(negedge clk_sys_i);
    check(w, disp_o.mode, m);
  endtask
  task automatic tap(input int b);
    op.press(b, 5);
  endtask
  // code digits go in leftmost first
  task automatic enter_code(input logic [15:0] c);
    for (int k = 3; k >= 0; k--)
    begin
      repeat (int'(c[k*4 +: 4])) tap(UP);
      tap(EN);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // every store pulse is matched with the oldest note
  always @(negedge clk_sys_i)
  begin
    if (commit_o === 1'b1 && exp_q.size() == 0)
      check("store", 32'h1, 32'h0);
    else if (commit_o === 1'b1)
    begin
      e = exp_q.pop_front();
      check("quick", commit_data_o.quick, e.quick);
      if (e.list)
        check("option", commit_data_o.option, e.option);
      else
        check("value", commit_data_o.value, e.value);
    end
  end
  // a hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    n_mismatch++;
    final_report;
  end
  initial
  begin
    lfsr_q = lfsr_next(lfsr_q);
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    thr_value_i <= 16'(lfsr_q[12:0]);
    mode_is("reset", DISP_MEAS);
    check("reset store", commit_o, 32'h0);
    tap(UP);
    mode_is("quick", DISP_THR_NAME);
    tap(DN);
    check("quick next", disp_o.index, 32'h1);
    tap(EN);
    check("locked", disp_o.mode inside {DISP_THR_NAME, DISP_THR_VALUE},
          32'h1);
    tap(BK);
    mode_is("quick end", DISP_MEAS);
    @(posedge clk_sys_i) free_access_i <= 1'b1;
    // quick edit of threshold 0, then its new value shown
    tap(UP);
    tap(EN);
    check("quick edit", disp_o.value, thr_value_i);
    op.press(EN, LONG);
    exp_q.push_back('{1'b1, 1'b0, 4'h0, thr_value_i});
    tap(EN);
    check("shown", disp_o.mode inside {DISP_THR_NAME, DISP_THR_VALUE},
          32'h1);
    repeat (300 * TC) @(posedge clk_sys_i);
    mode_is("shown end", DISP_MEAS);
    op.press(BK, LONG);
    mode_is("menu", DISP_ITEM_NAME);
    check("level", disp_o.level, 32'h0);
    tap(DN);
    check("wrap", disp_o.index, 32'h3);
    tap(UP);
    check("index", disp_o.index, 32'h0);
    @(posedge clk_sys_i) item_is_menu_i <= 1'b1;
    tap(EN);
    check("sub", disp_o.level, 32'h1);
    @(posedge clk_sys_i) item_is_menu_i <= 1'b0;
    tap(BK);
    check("up level", disp_o.level, 32'h0);
    lfsr_q = lfsr_next(lfsr_q);
    v = 16'(lfsr_q % 32'd1000);
    @(posedge clk_sys_i) value_i <= v;
    tap(EN);
    mode_is("edit", DISP_VALUE);
    tap(UP);
    tap(EN);
    tap(UP);
    check("digits", disp_o.value, v + 16'sd1100);
    check("pos", disp_o.digit, 32'h1);
    op.press(EN, LONG);
    mode_is("query", DISP_CONFIRM);
    exp_q.push_back('{1'b0, 1'b0, 4'h0, v + 16'sd1100});
    tap(EN);
    mode_is("stored", DISP_ITEM_NAME);
    // slide edit steps by one, then cancelled at the query
    @(posedge clk_sys_i) edit_slide_i <= 1'b1;
    tap(EN);
    tap(UP);
    check("slide", disp_o.value, v + 16'sd1);
    tap(DN);
    check("slide down", disp_o.value, v);
    op.press(EN, LONG);
    tap(BK);
    mode_is("cancel", DISP_ITEM_NAME);
    @(posedge clk_sys_i) item_is_list_i <= 1'b1;
    tap(EN);
    mode_is("list", DISP_LIST);
    tap(UP);
    tap(UP);
    check("list wrap", disp_o.option, 32'h0);
    tap(EN);
    mode_is("list query", DISP_CONFIRM);
    exp_q.push_back('{1'b0, 1'b1, 4'h0, 16'sh0000});
    tap(EN);
    @(posedge clk_sys_i) item_is_list_i <= 1'b0;
    tap(BK);
    mode_is("leave", DISP_MEAS);
    @(posedge clk_sys_i) password_i <= 16'h1200;
    op.press(BK, LONG);
    mode_is("code", DISP_PASS);
    tap(UP);
    check("code digit", disp_o.value, 32'h1);
    repeat (4) tap(EN);
    mode_is("bad code", DISP_PASS_ERR);
    repeat (200 * TC) @(posedge clk_sys_i);
    mode_is("after bad", DISP_MEAS);
    op.press(BK, LONG);
    enter_code(password_i);
    mode_is("good code", DISP_ITEM_NAME);
    repeat (6010 * TC) @(posedge clk_sys_i);
    mode_is("idle", DISP_MEAS);
    tap(UP);
    repeat (505 * TC) @(posedge clk_sys_i);
    mode_is("quick idle", DISP_MEAS);
    check("pending", exp_q.size(), 32'h0);
    final_report;
  end
endmodule
